// ### design/cbx_branch.sv
/*
 * conditional branch executer of an 8-bit core: decodes three
 * flag-tested relative branches and steps the program counter.
 * assumes the instruction word is held stable by the fetch logic for a
 * whole instruction cycle and that the flags come from the same clock.
 */
// How it works
// - high byte e6: branch when negative set
// - high byte e3: branch when carry clear
// - high byte e7: branch when negative clear
// - target is incremented counter plus doubled offset
// - one word; one cycle, two if taken
// - taken: pc loads q4, then empty cycle
// - not taken: counter ends at address plus two
`timescale 1ns/1ps
module cbx_branch #(
    parameter int PCW = cbx_pkg::PC_WIDTH // program counter width
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // instruction and flags from the core
    input wire logic [15:0] instr_word,
    input wire logic flag_negative,
    input wire logic flag_carry,
    // program counter and status
    output logic [PCW-1:0] program_counter,
    output logic branch_taken,
    output logic flush_cycle,
    output logic negative_out,
    output logic carry_out
);
    // ------------------------------------------------------------
    // phase generation
    // ------------------------------------------------------------
    cbx_pkg::cbx_phase_t phase; // current quarter
    logic cycle_end; // high in q4
    cbx_pkg::cbx_state_t state; // fetch or flush
    logic [7:0] offset_lit; // literal latched in q2
    logic cond_true; // condition evaluated in q3
    logic [PCW-1:0] target; // computed in q3

    // one shared counter, so every process agrees on the quarter
    cbx_phase_gen u_phase (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    // ------------------------------------------------------------
    // decode function
    // ------------------------------------------------------------
    // returns 1 if the word is one of ours and its condition holds
    function automatic logic cond_met(input logic [7:0] hi,
                                      input logic n, input logic c);
        case (hi)
            cbx_pkg::OP_BRANCH_ON_NEGATIVE: cond_met = n;
            cbx_pkg::OP_BRANCH_ON_NO_CARRY: cond_met = ~c;
            cbx_pkg::OP_BRANCH_ON_NOT_NEGATIVE: cond_met = ~n;
            default: cond_met = 1'b0;
        endcase
    endfunction : cond_met

    // ------------------------------------------------------------
    // q2: latch literal
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            offset_lit <= 8'h00;
        end else if (phase == cbx_pkg::CBX_Q2 &&
                     state == cbx_pkg::CBX_FETCH) begin
            offset_lit <= instr_word[7:0];
        end
    end

    // ------------------------------------------------------------
    // q3: evaluate condition and target
    // ------------------------------------------------------------
    // pc already points past this word here, so target = pc + 2n
    // the literal was latched one quarter earlier, so it is settled here
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cond_true <= 1'b0;
            target <= '0;
        end else if (phase == cbx_pkg::CBX_Q3 &&
                     state == cbx_pkg::CBX_FETCH) begin
            cond_true <= cond_met(instr_word[15:8], flag_negative,
                                  flag_carry);
            // sign extend then double
            target <= program_counter +
                      PCW'({{(PCW-9){offset_lit[7]}}, offset_lit, 1'b0});
        end
    end

    // ------------------------------------------------------------
    // program counter and state; pc bumped in q1, branch and state change at end of q4
    // ------------------------------------------------------------
    // the counter is bumped in q1 of a fetch cycle, modelling fetch of
    // the next word; a taken branch overwrites it in q4
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            program_counter <= cbx_pkg::PC_RESET[PCW-1:0];
            state <= cbx_pkg::CBX_FETCH;
            branch_taken <= 1'b0;
            flush_cycle <= 1'b0;
        end else begin
            case (state)
                cbx_pkg::CBX_FETCH: begin
                    if (phase == cbx_pkg::CBX_Q1) begin
                        // one word per branch
                        program_counter <= program_counter +
                            PCW'(cbx_pkg::WORD_BYTES);
                        branch_taken <= 1'b0;
                    end else if (cycle_end && cond_true) begin
                        program_counter <= target;
                        branch_taken <= 1'b1;
                        state <= cbx_pkg::CBX_FLUSH;
                        flush_cycle <= 1'b1;
                    end
                end
                cbx_pkg::CBX_FLUSH: begin
                    // no operation in any quarter
                    branch_taken <= 1'b0;
                    if (cycle_end) begin
                        state <= cbx_pkg::CBX_FETCH;
                        flush_cycle <= 1'b0;
                    end
                end
                default: begin
                    // only reached from a corrupted state register
                    state <= cbx_pkg::CBX_FETCH;
                    flush_cycle <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags pass through unchanged
    // ------------------------------------------------------------
    // the branch unit never writes status; it only registers the copy
    // a register here keeps every top output on a flip-flop
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            negative_out <= 1'b0;
            carry_out <= 1'b0;
        end else begin
            negative_out <= flag_negative;
            carry_out <= flag_carry;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // the flag copy lags by one edge, so the edge right after a reset
    // release still shows the reset value and is left out
    AST_FLAGS_KEPT: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !$past(sys_rst) |->
        negative_out == $past(flag_negative) &&
        carry_out == $past(flag_carry))
        else $error("flag copy altered");
    AST_TAKEN_FLUSH: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(flush_cycle) |-> flush_cycle [*4] ##1 !flush_cycle)
        else $error("flush cycle not four quarters");
    AST_FLUSH_PC_HOLD: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (state == cbx_pkg::CBX_FLUSH && !cycle_end) |=>
        $stable(program_counter))
        else $error("pc moved in flush cycle");
    AST_TAKEN_IN_Q4: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(branch_taken) |-> $past(phase) == cbx_pkg::CBX_Q4)
        else $error("branch taken outside q4");
    AST_TAKEN_PULSE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        branch_taken |=> !branch_taken)
        else $error("taken pulse longer than one quarter");
    AST_FLUSH_NO_LATCH: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (state == cbx_pkg::CBX_FLUSH) |=> $stable(offset_lit))
        else $error("literal latched in flush cycle");
    AST_NEG_TAKE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (phase == cbx_pkg::CBX_Q3 && state == cbx_pkg::CBX_FETCH &&
         instr_word[15:8] == cbx_pkg::OP_BRANCH_ON_NEGATIVE) |=>
        cond_true == $past(flag_negative))
        else $error("negative branch condition wrong");
    AST_NC_TAKE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (phase == cbx_pkg::CBX_Q3 && state == cbx_pkg::CBX_FETCH &&
         instr_word[15:8] == cbx_pkg::OP_BRANCH_ON_NO_CARRY) |=>
        cond_true == !$past(flag_carry))
        else $error("no-carry branch condition wrong");
    AST_NN_TAKE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (phase == cbx_pkg::CBX_Q3 && state == cbx_pkg::CBX_FETCH &&
         instr_word[15:8] == cbx_pkg::OP_BRANCH_ON_NOT_NEGATIVE) |=>
        cond_true == !$past(flag_negative))
        else $error("not-negative branch condition wrong");
    AST_TARGET: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(branch_taken) |-> program_counter == $past(target))
        else $error("branch target not loaded");
    AST_NOT_TAKEN_PC: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (phase == cbx_pkg::CBX_Q1 && state == cbx_pkg::CBX_FETCH) |=>
        program_counter == $past(program_counter) + PCW'(2))
        else $error("pc not advanced by one word");
    AST_NOT_TAKEN_STAY: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (cycle_end && state == cbx_pkg::CBX_FETCH && !cond_true) |=>
        $stable(program_counter))
        else $error("pc moved at q4 of a branch not taken");
    // main scenarios: taken, not taken, backward jump, end of flush
    COV_TAKEN: cover property (@(posedge sys_clk) $rose(branch_taken));
    COV_FLUSH_DONE: cover property (@(posedge sys_clk) $fell(flush_cycle));
    COV_NOT_TAKEN: cover property (@(posedge sys_clk)
        cycle_end && state == cbx_pkg::CBX_FETCH && !cond_true &&
        instr_word[15:8] == cbx_pkg::OP_BRANCH_ON_NO_CARRY);
    COV_BACKWARD: cover property (@(posedge sys_clk)
        $rose(branch_taken) && offset_lit[7]);
endmodule : cbx_branch

// ### design/cbx_phase_gen.sv
/*
 * quarter-phase generator: splits each instruction cycle into four
 * sys_clk periods and flags the last one.
 * assumes sys_clk is the quarter-phase clock of the core.
 */
`timescale 1ns/1ps
module cbx_phase_gen (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // phase outputs
    output cbx_pkg::cbx_phase_t phase,
    output logic cycle_end
);
    // ------------------------------------------------------------
    // phase counter
    // ------------------------------------------------------------
    // free-running, wraps q4 -> q1
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= cbx_pkg::CBX_Q1;
        end else begin
            phase <= cbx_pkg::cbx_phase_t'(phase + 2'b01);
        end
    end
    // combinational end-of-cycle flag, true during q4
    assign cycle_end = (phase == cbx_pkg::CBX_Q4);
endmodule : cbx_phase_gen

// ### design/cbx_pkg.sv
/*
 * package for the conditional branch executer: opcode patterns, phase
 * encoding, program counter width and reset values.
 * assumes a byte-addressed program memory with 16-bit instruction words.
 */
package cbx_pkg;
    // ------------------------------------------------------------
    // opcode high-byte patterns
    // ------------------------------------------------------------
    localparam logic [7:0] OP_BRANCH_ON_NEGATIVE = 8'he6;
    localparam logic [7:0] OP_BRANCH_ON_NO_CARRY = 8'he3;
    localparam logic [7:0] OP_BRANCH_ON_NOT_NEGATIVE = 8'he7;
    // ------------------------------------------------------------
    // sizes and counts
    // ------------------------------------------------------------
    localparam int PC_WIDTH = 21; // program counter width in bits
    localparam int WORD_BYTES = 2; // one instruction word, in bytes
    localparam int TAKEN_CYCLES = 2; // instruction cycles when taken
    localparam int NOT_TAKEN_CYCLES = 1; // instruction cycles otherwise
    localparam logic [20:0] PC_RESET = 21'h00_0000; // program counter reset
    // ------------------------------------------------------------
    // quarter phases of one instruction cycle
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CBX_Q1 = 2'b00,
        CBX_Q2 = 2'b01,
        CBX_Q3 = 2'b10,
        CBX_Q4 = 2'b11
    } cbx_phase_t;
    // execution state of the branch unit
    typedef enum logic [1:0] {
        CBX_FETCH = 2'b00, // decoding a fresh word
        CBX_FLUSH = 2'b01 // second, empty cycle of a taken branch
    } cbx_state_t;
endpackage : cbx_pkg

// ### sim/test_conditional_branch_exec.sv
/*
 * self-checking bench for the conditional branch executer: drives
 * instruction words and flags, then checks the counter, the taken pulse,
 * the flush level and the flag copies.
 * assumes cbx_pkg and the design modules are compiled first.
 */
`timescale 1ns/1ps
module test_conditional_branch_exec;
    // ------------------------------------------------------------
    // stimulus, observed outputs and the design
    // ------------------------------------------------------------
    logic sys_clk = 1'b0; // quarter-phase clock
    logic sys_rst = 1'b1; // held from time zero
    logic [15:0] instr_word = 16'h0000; // opcode and offset
    logic flag_negative = 1'b0;
    logic flag_carry = 1'b0;
    logic [20:0] program_counter;
    logic branch_taken, flush_cycle, negative_out, carry_out;
    logic [20:0] exp_pc = 21'h00_0000; // bench copy of the counter
    int failures = 0;
    int checks_done = 0;

    // 200 MHz, each rising edge one quarter
    always #2.5 sys_clk = ~sys_clk;

    cbx_branch #(.PCW(cbx_pkg::PC_WIDTH)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .flag_negative(flag_negative), .flag_carry(flag_carry),
        .program_counter(program_counter), .branch_taken(branch_taken),
        .flush_cycle(flush_cycle), .negative_out(negative_out),
        .carry_out(carry_out));

    // ------------------------------------------------------------
    // compare tasks, one per kind of result
    // ------------------------------------------------------------
    task automatic cmp_pc(input string what, input logic [20:0] exp,
                          input logic [20:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp_pc

    task automatic cmp_bit(input string what, input logic exp,
                           input logic seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask : cmp_bit

    // ------------------------------------------------------------
    // one instruction: entered and left just after a falling edge
    // ------------------------------------------------------------
    task automatic run_instr(input logic [7:0] op, input logic [7:0] off,
                             input logic n, input logic c);
        logic tk;
        logic [20:0] tgt;
        // opcodes written out here so a wrong package constant shows
        tk = (op == 8'he6 && n) || (op == 8'he3 && !c) || (op == 8'he7 && !n);
        tgt = exp_pc + 21'h2 + {{12{off[7]}}, off, 1'b0};
        instr_word = {op, off};
        flag_negative = n;
        flag_carry = c;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        exp_pc = tk ? tgt : exp_pc + 21'h2;
        cmp_pc("counter after q4", exp_pc, program_counter);
        cmp_bit("taken pulse", tk, branch_taken);
        cmp_bit("flush level", tk, flush_cycle);
        cmp_bit("negative copy", n, negative_out);
        cmp_bit("carry copy", c, carry_out);
        if (tk) begin
            // a word that would branch: the empty cycle must ignore it
            instr_word = {(n ? 8'he6 : 8'he7), 8'h10};
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            cmp_bit("taken drop", 1'b0, branch_taken);
            cmp_bit("flush held", 1'b1, flush_cycle);
            cmp_pc("counter in flush", exp_pc, program_counter);
            @(posedge sys_clk);
            @(negedge sys_clk);
            cmp_bit("flush end", 1'b0, flush_cycle);
            cmp_pc("counter after flush", exp_pc, program_counter);
        end
    endtask : run_instr

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_opcodes();
        run_instr(8'he6, 8'h05, 1'b1, 1'b0);
        run_instr(8'he6, 8'h05, 1'b0, 1'b1);
        run_instr(8'he3, 8'hfe, 1'b1, 1'b0);
        run_instr(8'he3, 8'hfe, 1'b0, 1'b1);
        run_instr(8'he7, 8'h7f, 1'b0, 1'b1);
        run_instr(8'he7, 8'h7f, 1'b1, 1'b0);
    endtask : sc_opcodes

    task automatic sc_offsets();
        // extreme offsets back to back, then zero
        run_instr(8'he6, 8'h80, 1'b1, 1'b1);
        run_instr(8'he3, 8'h7f, 1'b0, 1'b0);
        run_instr(8'he7, 8'h00, 1'b0, 1'b0);
    endtask : sc_offsets

    task automatic sc_other_ops();
        // neighbouring encodings, and d0, must step by one word only
        run_instr(8'he2, 8'h10, 1'b1, 1'b1);
        run_instr(8'he5, 8'h10, 1'b0, 1'b0);
        run_instr(8'he4, 8'h10, 1'b1, 1'b0);
        run_instr(8'hd0, 8'h10, 1'b0, 1'b0);
    endtask : sc_other_ops

    task automatic sc_reset_midrun();
        // reset lands mid-instruction; phase restarts at q1
        instr_word = 16'he640;
        flag_negative = 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        @(negedge sys_clk);
        cmp_pc("counter in reset", 21'h00_0000, program_counter);
        cmp_bit("flush in reset", 1'b0, flush_cycle);
        sys_rst = 1'b0;
        exp_pc = 21'h00_0000;
        run_instr(8'he6, 8'h03, 1'b1, 1'b0);
    endtask : sc_reset_midrun

    // ------------------------------------------------------------
    // main sequence, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        sc_opcodes();
        sc_offsets();
        sc_other_ops();
        sc_reset_midrun();
        close_out();
    end

    // about 107 quarters are needed; allow over thirty-five times that
    initial begin
        #20000;
        failures++;
        close_out();
    end

    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
endmodule : test_conditional_branch_exec
